/* pkg/switch_ctrl_pkg.sv */
// Constants, register map and timing for the global control bit block.
// Assumes a 25 MHz core clock shared by the bus and the switch logic.
package switch_ctrl_pkg;
  // Clock and aging times
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned FAST_AGE_US = 800;
  localparam int unsigned NORMAL_AGE_S = 300;
  // Longest fast-age time rounds down to whole cycles
  localparam int unsigned FAST_AGE_CYC = CLK_HZ / US_PER_S * FAST_AGE_US;
  // Normal period counted in fast-age ticks
  localparam int unsigned NORMAL_AGE_TICKS =
    NORMAL_AGE_S * (US_PER_S / FAST_AGE_US);
  // Strap settling cycles after reset release
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Register indices and byte addresses (index times four)
  localparam logic [7:0] GC0_IDX = 8'h02;
  localparam logic [7:0] GC1_IDX = 8'h03;
  localparam logic [7:0] STAT_IDX = 8'h10;
  localparam logic [31:0] GC0_ADDR = {22'h000000, GC0_IDX, 2'h0};
  localparam logic [31:0] GC1_ADDR = {22'h000000, GC1_IDX, 2'h0};
  localparam logic [31:0] STAT_ADDR = {22'h000000, STAT_IDX, 2'h0};

  // First control register fields
  localparam int GC0_FLUSH = 4;
  localparam int GC0_COMPL = 1;
  localparam int GC0_LINKAGE = 0;
  localparam logic [7:0] GC0_WR_MASK = 8'h03;
  localparam logic [7:0] GC0_RESV_ONES = 8'h0C;
  localparam logic [7:0] GC0_RESET = 8'h00;

  // Second control register fields
  localparam int GC1_BIG = 6;
  localparam int GC1_TXDIS = 5;
  localparam int GC1_RXDIS = 4;
  localparam int GC1_LENCHK = 3;
  localparam int GC1_AGE = 2;
  localparam int GC1_FAST = 1;
  localparam int GC1_BACKOFF = 0;
  localparam logic [7:0] GC1_WR_MASK = 8'h7F;
  localparam logic [7:0] GC1_RESET = 8'h04;

  // Status register fields
  localparam int STAT_BUSY = 8;
  localparam int STAT_PEND = 9;

  // Frame classification constants
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA = 48'h0180C2000001;
  localparam logic [15:0] LEN_LIMIT = 16'h05DC;

  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Static flush engine states
  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_SCAN = 2'b01
  } flush_state_t;
endpackage

/* pkg/flush_if.sv */
// Handshake between the register bank and the static flush engine.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface flush_if;
  logic start;
  logic busy;
  logic done;
  modport engine (input start, output busy, output done);
  modport ctrl (output start, input busy, input done);
endinterface // flush_if

/* design/static_flush.sv */
// Static address table flush engine: walks every entry once per start.
// Assumes the table read port answers combinationally on the same clock.
`timescale 1ns/1ps
module static_flush
  import switch_ctrl_pkg::*;
#(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned NPORTS = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control handshake
  flush_if.engine fl,
  // Static table read and remove port
  output logic [$clog2(DEPTH)-1:0] table_addr,
  input wire logic table_valid,
  input wire logic [NPORTS-1:0] table_fwd,
  input wire logic table_mcast,
  input wire logic [NPORTS-1:0] learn_disable,
  output logic table_remove,
  output logic [$clog2(DEPTH)-1:0] remove_addr
);
  localparam logic [$clog2(DEPTH)-1:0] LAST = ($clog2(DEPTH))'(DEPTH - 1);

  flush_state_t state_reg;
  logic done_reg;
  logic match;

  ////////////////////////////////////////////////////////////////////////
  // Entry qualifies: one port, unicast, that port not learning
  assign match = table_valid && !table_mcast && (table_fwd != '0)
    && ((table_fwd & (table_fwd - 1'b1)) == '0)
    && ((table_fwd & learn_disable) != '0);

  // Scan sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= FL_IDLE;
      table_addr <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        FL_IDLE: begin
          table_addr <= '0;
          if (fl.start) begin
            state_reg <= FL_SCAN;
          end
        end
        FL_SCAN: begin
          table_addr <= table_addr + 1'b1;
          if (table_addr == LAST) begin
            state_reg <= FL_IDLE;
            done_reg <= 1'b1;
          end
        end
        // Unused codes fall back to idle
        default: begin
          state_reg <= FL_IDLE;
        end
      endcase
    end
  end

  // Removal strobe for every matched entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_remove <= 1'b0;
      remove_addr <= '0;
    end else begin
      table_remove <= (state_reg == FL_SCAN) && match;
      remove_addr <= table_addr;
    end
  end

  assign fl.busy = (state_reg == FL_SCAN);
  assign fl.done = done_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_flush_ends_bounded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fl.start && !fl.busy |-> ##[1:40] fl.done)
    else $error("flush did not finish in time");
  a_remove_qualified: assert property (
    @(posedge hclk) disable iff (!hresetn)
    table_remove |-> $past(match) && $past(fl.busy))
    else $error("removed an entry that does not qualify");
endmodule // static_flush

/* design/switch_global_control_bits.sv */
// Global control bits of a five-port switch, reached over AHB-Lite.
// Assumes frame header fields and link states arrive from core logic.
//
// Summary of operation
// - Writing one to the flush bit starts a static table flush.
// - Only single-port unicast entries on a non-learning port go.
// - Compliance mode drops type 0x8808 or the pause group address.
// - Without compliance mode only classified flow frames and length check failures drop.
// - Link loss with link aging on runs one fast age, then normal.
// - That link-loss age cycle ages out every learned address.
// - The large frame bit enables 2KB frames; reset leaves it off.
// - Transmit pause follows autonegotiation unless disabled.
// - Receive pause follows autonegotiation unless disabled.
// - Both pause disable bits load from one strap, then stand apart.
// - Length check drops frames whose length field lies below 1500 and differs from the payload length.
// - Aging runs while the aging bit is one, its reset value.
// - The back-off bit selects aggressive half-duplex back-off.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module switch_global_control_bits
  import switch_ctrl_pkg::*;
#(
  parameter int unsigned NPORTS = 5,
  parameter int unsigned TABLE_DEPTH = 32,
  parameter int unsigned PRESCALE_CYC = FAST_AGE_CYC,
  parameter int unsigned NORMAL_TICKS = NORMAL_AGE_TICKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Strap and link pins
  input wire logic pause_strap,
  input wire logic [NPORTS-1:0] link_up,
  // Frame header check
  input wire logic hdr_valid,
  input wire logic [15:0] hdr_len_type,
  input wire logic [47:0] hdr_da,
  input wire logic hdr_is_flow_ctrl,
  input wire logic [15:0] hdr_payload_len,
  output logic frame_drop,
  output logic frame_drop_valid,
  // Pause resolution
  input wire logic [NPORTS-1:0] an_tx_pause,
  input wire logic [NPORTS-1:0] an_rx_pause,
  output logic [NPORTS-1:0] tx_fc_en,
  output logic [NPORTS-1:0] rx_fc_en,
  // Mode levels
  output logic large_frame_en,
  output logic aggressive_backoff_en,
  // Aging strobes
  output logic age_tick,
  output logic age_all,
  // Static table port
  output logic [$clog2(TABLE_DEPTH)-1:0] table_addr,
  input wire logic table_valid,
  input wire logic [NPORTS-1:0] table_fwd,
  input wire logic table_mcast,
  input wire logic [NPORTS-1:0] learn_disable,
  output logic table_remove,
  output logic [$clog2(TABLE_DEPTH)-1:0] remove_addr
);
  localparam int PW = $clog2(PRESCALE_CYC);
  localparam int NW = $clog2(NORMAL_TICKS);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_CYC - 1);
  localparam logic [NW-1:0] NORM_LAST = NW'(NORMAL_TICKS - 1);

  flush_if fl ();

  logic [7:0] gc0_reg;
  logic [7:0] gc1_reg;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic flush_start_reg;
  logic flush_bit;
  logic [1:0] strap_sync_reg;
  logic [1:0] strap_cnt_reg;
  logic [NPORTS-1:0] link_meta_reg;
  logic [NPORTS-1:0] link_sync_reg;
  logic [NPORTS-1:0] link_prev_reg;
  logic link_drop;
  logic link_pend_reg;
  logic [PW-1:0] pre_cnt_reg;
  logic [NW-1:0] norm_cnt_reg;
  logic fast_tick;
  logic addr_phase;
  logic gc1_wr;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign gc1_wr = wr_pend_reg && (wr_addr_reg == GC1_ADDR);

  // Flush bit shows start or engine busy
  assign flush_bit = flush_start_reg || fl.busy;

  // Read mux, unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    unique case (haddr)
      GC0_ADDR: begin
        rd_word[7:0] = gc0_reg | GC0_RESV_ONES;
        rd_word[GC0_FLUSH] = flush_bit;
      end
      GC1_ADDR: rd_word[7:0] = gc1_reg;
      STAT_ADDR: begin
        rd_word[NPORTS-1:0] = link_sync_reg;
        rd_word[STAT_BUSY] = fl.busy;
        rd_word[STAT_PEND] = link_pend_reg;
      end
      default: rd_word = '0;
    endcase
  end

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata <= '0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
      if (addr_phase && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // First control register and flush trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gc0_reg <= GC0_RESET;
      flush_start_reg <= 1'b0;
    end else begin
      flush_start_reg <= 1'b0;
      if (wr_pend_reg && wr_addr_reg == GC0_ADDR) begin
        gc0_reg <= hwdata[7:0] & GC0_WR_MASK;
        flush_start_reg <= hwdata[GC0_FLUSH] && !fl.busy;
      end
    end
  end

  assign fl.start = flush_start_reg;

  // Strap synchroniser and delayed load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_sync_reg <= 2'h0;
      strap_cnt_reg <= 2'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], pause_strap};
      if (strap_cnt_reg != STRAP_WAIT) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  // Second control register, software write wins over strap load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gc1_reg <= GC1_RESET;
    end else if (gc1_wr) begin
      gc1_reg <= hwdata[7:0] & GC1_WR_MASK;
    end else if (strap_cnt_reg == STRAP_WAIT - 2'h1) begin
      gc1_reg[GC1_TXDIS] <= strap_sync_reg[1];
      gc1_reg[GC1_RXDIS] <= strap_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode levels and pause resolution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_fc_en <= '0;
      rx_fc_en <= '0;
      large_frame_en <= 1'b0;
      aggressive_backoff_en <= 1'b0;
    end else begin
      tx_fc_en <= an_tx_pause & ~{NPORTS{gc1_reg[GC1_TXDIS]}};
      rx_fc_en <= an_rx_pause & ~{NPORTS{gc1_reg[GC1_RXDIS]}};
      large_frame_en <= gc1_reg[GC1_BIG];
      aggressive_backoff_en <= gc1_reg[GC1_BACKOFF];
    end
  end

  // Per-frame drop decision, one cycle after the header
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_drop <= 1'b0;
      frame_drop_valid <= 1'b0;
    end else begin
      frame_drop_valid <= hdr_valid;
      if (hdr_valid) begin
        frame_drop <= (gc0_reg[GC0_COMPL]
            ? (hdr_len_type == PAUSE_TYPE || hdr_da == PAUSE_DA)
            : hdr_is_flow_ctrl)
          || (gc1_reg[GC1_LENCHK] && hdr_len_type < LEN_LIMIT
            && hdr_len_type != hdr_payload_len);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link state synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_meta_reg <= '0;
      link_sync_reg <= '0;
      link_prev_reg <= '0;
    end else begin
      link_meta_reg <= link_up;
      link_sync_reg <= link_meta_reg;
      link_prev_reg <= link_sync_reg;
    end
  end

  assign link_drop = (link_prev_reg & ~link_sync_reg) != '0;

  // Fast-age prescaler gives one tick per fast period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_reg <= '0;
    end else if (pre_cnt_reg == PRE_LAST) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end
  end

  assign fast_tick = (pre_cnt_reg == PRE_LAST);

  // Pending link-loss age, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_pend_reg <= 1'b0;
    end else if (link_drop && gc0_reg[GC0_LINKAGE]) begin
      link_pend_reg <= 1'b1;
    end else if (fast_tick) begin
      link_pend_reg <= 1'b0;
    end
  end

  // Normal, fast and link-loss age strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      norm_cnt_reg <= '0;
      age_tick <= 1'b0;
      age_all <= 1'b0;
    end else begin
      age_tick <= 1'b0;
      age_all <= 1'b0;
      if (fast_tick && gc1_reg[GC1_AGE]) begin
        if (link_pend_reg) begin
          age_all <= 1'b1;
          age_tick <= 1'b1;
          norm_cnt_reg <= '0;
        end else if (gc1_reg[GC1_FAST]) begin
          age_tick <= 1'b1;
          norm_cnt_reg <= '0;
        end else if (norm_cnt_reg == NORM_LAST) begin
          age_tick <= 1'b1;
          norm_cnt_reg <= '0;
        end else begin
          norm_cnt_reg <= norm_cnt_reg + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Static flush engine
  static_flush #(
    .DEPTH(TABLE_DEPTH),
    .NPORTS(NPORTS)
  ) static_flush_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .fl(fl.engine),
    .table_addr(table_addr),
    .table_valid(table_valid),
    .table_fwd(table_fwd),
    .table_mcast(table_mcast),
    .learn_disable(learn_disable),
    .table_remove(table_remove),
    .remove_addr(remove_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_flush;
    addr_phase && hwrite && haddr == GC0_ADDR && !fl.busy
      ##1 hwdata[GC0_FLUSH];
  endsequence
  sequence s_rd_gc0;
    addr_phase && !hwrite && haddr == GC0_ADDR;
  endsequence

  a_flush_bit_set: assert property (
    s_wr_flush |=> flush_bit ##1 fl.busy)
    else $error("flush write did not start the engine");
  a_flush_bit_clear: assert property (
    fl.done |-> !flush_bit)
    else $error("flush bit still set after completion");
  a_resv_ones_read: assert property (
    s_rd_gc0 |=> hrdata[3:2] == 2'h3 && hrdata[7:5] == 3'h0)
    else $error("reserved bits read wrong");
  a_tx_pause_off: assert property (
    gc1_reg[GC1_TXDIS] && $past(gc1_reg[GC1_TXDIS]) |-> tx_fc_en == '0)
    else $error("transmit pause on while disabled");
  a_rx_pause_follow: assert property (
    !gc1_reg[GC1_RXDIS] ##1 !gc1_reg[GC1_RXDIS] |-> rx_fc_en
      == $past(an_rx_pause))
    else $error("receive pause does not follow negotiation");
  a_compl_drop: assert property (
    hdr_valid && gc0_reg[GC0_COMPL] && hdr_da == PAUSE_DA
      |=> frame_drop && frame_drop_valid)
    else $error("pause group frame not dropped");
  a_flow_drop: assert property (
    hdr_valid && !gc0_reg[GC0_COMPL] && hdr_is_flow_ctrl |=> frame_drop)
    else $error("flow control frame not dropped");
  a_len_mismatch: assert property (
    hdr_valid && gc1_reg[GC1_LENCHK] && hdr_len_type < LEN_LIMIT
      && hdr_len_type != hdr_payload_len |=> frame_drop)
    else $error("length mismatch not dropped");
  a_aging_off: assert property (
    !gc1_reg[GC1_AGE] && $past(!gc1_reg[GC1_AGE]) |-> !age_tick && !age_all)
    else $error("aging ran while disabled");
  a_fast_tick: assert property (
    fast_tick && gc1_reg[GC1_AGE] && gc1_reg[GC1_FAST] |=> age_tick)
    else $error("fast aging tick missing");
  a_link_age_all: assert property (
    link_pend_reg && fast_tick && gc1_reg[GC1_AGE] |=> age_all && age_tick)
    else $error("link loss did not age the table");
endmodule // switch_global_control_bits

/* bench/switch_global_control_bits_bench.sv */
// Self-checking bench for the global control bit block over AHB-Lite.
// Assumes the block is the only slave; aging counts shortened by params.
`timescale 1ns/1ps
module switch_global_control_bits_bench;
  import switch_ctrl_pkg::*;
  // Clock and reset
  logic hclk;
  logic hresetn;
  // Bus
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // Straps, links, headers, pause
  logic pause_strap;
  logic [4:0] link_up;
  logic hdr_valid;
  logic [15:0] hdr_len_type;
  logic [47:0] hdr_da;
  logic hdr_is_flow_ctrl;
  logic [15:0] hdr_payload_len;
  logic frame_drop;
  logic frame_drop_valid;
  logic [4:0] an_tx_pause;
  logic [4:0] an_rx_pause;
  logic [4:0] tx_fc_en;
  logic [4:0] rx_fc_en;
  logic large_frame_en;
  logic aggressive_backoff_en;
  logic age_tick;
  logic age_all;
  // Static table
  logic [4:0] table_addr;
  logic table_valid;
  logic [4:0] table_fwd;
  logic table_mcast;
  logic [4:0] learn_disable;
  logic table_remove;
  logic [4:0] remove_addr;
  // Bookkeeping
  int fail_count;
  int cmp_count;
  int tick_count;
  int all_count;
  logic [31:0] rm_mask;
  logic [31:0] v;

  assign hready = hreadyout;

  switch_global_control_bits #(.PRESCALE_CYC(8), .NORMAL_TICKS(4))
    switch_global_control_bits_i (.*);

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Table answers: only entries 0, 8 and 16 qualify
  always_comb begin
    table_valid = (table_addr != 5'h18);
    table_fwd = table_addr[0] ? 5'h03 : (table_addr[2] ? 5'h02 : 5'h01);
    table_mcast = table_addr[1];
  end

  // Removal and aging monitors
  always @(posedge hclk) begin
    if (table_remove === 1'b1) rm_mask[remove_addr] = 1'b1;
    if (age_tick === 1'b1) tick_count++;
    if (age_all === 1'b1 && age_tick === 1'b1) all_count++;
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for hready; only the watchdog ends a stuck wait
  task automatic wait_rdy;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h00000000, r);
  endtask

  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask

  // One header through the drop check
  task automatic hdr(input logic [15:0] lt, input logic [47:0] da,
                     input logic fc, input logic [15:0] pl, input logic e);
    @(posedge hclk);
    hdr_valid <= 1'b1;
    hdr_len_type <= lt;
    hdr_da <= da;
    hdr_is_flow_ctrl <= fc;
    hdr_payload_len <= pl;
    @(posedge hclk);
    hdr_valid <= 1'b0;
    #1;
    chk({31'h0, frame_drop_valid}, 32'h1);
    chk({31'h0, frame_drop}, {31'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    // Let the strap-driven pause enables settle first
    settle;
    chk({27'h0, tx_fc_en}, 32'h0);
    chk({27'h0, rx_fc_en}, 32'h0);
    chk({31'h0, large_frame_en}, 32'h0);
    rd(GC0_ADDR, v);
    chk(v, 32'h0000000C);
    rd(GC1_ADDR, v);
    chk(v, 32'h00000034);
    wr(GC1_ADDR, 32'hFFFFFFFF);
    rd(GC1_ADDR, v);
    chk(v, 32'h0000007F);
    chk({31'h0, large_frame_en}, 32'h1);
    chk({31'h0, aggressive_backoff_en}, 32'h1);
    wr(GC1_ADDR, 32'h00000004);
    settle;
    chk({31'h0, large_frame_en}, 32'h0);
    chk({31'h0, aggressive_backoff_en}, 32'h0);
    wr(GC0_ADDR, 32'h00000000);
    rd(GC0_ADDR, v);
    chk(v, 32'h0000000C);
    wr(32'h00000020, 32'h000000FF);
    rd(32'h00000020, v);
    chk(v, 32'h00000000);
    $display("test regs done");
  endtask

  task automatic t_pause;
    wr(GC1_ADDR, 32'h00000024);
    settle;
    chk({27'h0, tx_fc_en}, 32'h00);
    chk({27'h0, rx_fc_en}, 32'h0A);
    wr(GC1_ADDR, 32'h00000014);
    rd(GC1_ADDR, v);
    chk(v, 32'h00000014);
    chk({27'h0, tx_fc_en}, 32'h15);
    chk({27'h0, rx_fc_en}, 32'h00);
    @(posedge hclk);
    an_tx_pause <= 5'h0F;
    settle;
    chk({27'h0, tx_fc_en}, 32'h0F);
    $display("test pause done");
  endtask

  task automatic t_header;
    wr(GC0_ADDR, 32'h00000002);
    hdr(16'h8808, 48'h020000000000, 1'b0, 16'h0, 1'b1);
    hdr(16'h0800, PAUSE_DA, 1'b0, 16'h0, 1'b1);
    hdr(16'h0800, 48'h020000000000, 1'b1, 16'h0, 1'b0);
    wr(GC0_ADDR, 32'h00000000);
    hdr(16'h8808, PAUSE_DA, 1'b0, 16'h0, 1'b0);
    hdr(16'h0800, 48'h020000000000, 1'b1, 16'h0, 1'b1);
    wr(GC1_ADDR, 32'h0000000C);
    hdr(16'h0040, 48'h020000000000, 1'b0, 16'h0040, 1'b0);
    hdr(16'h0040, 48'h020000000000, 1'b0, 16'h0041, 1'b1);
    hdr(16'h05DC, 48'h020000000000, 1'b0, 16'h0000, 1'b0);
    hdr(16'h05DB, 48'h020000000000, 1'b0, 16'h0000, 1'b1);
    wr(GC1_ADDR, 32'h00000004);
    $display("test header done");
  endtask

  task automatic t_flush;
    rm_mask = 32'h0;
    wr(GC0_ADDR, 32'h00000010);
    rd(GC0_ADDR, v);
    chk(v, 32'h0000001C);
    for (int i = 0; i < 40 && v[4] !== 1'b0; i++) rd(GC0_ADDR, v);
    chk(v, 32'h0000000C);
    chk(rm_mask, 32'h00010101);
    $display("test flush done");
  endtask

  task automatic t_aging;
    wr(GC1_ADDR, 32'h00000006);
    tick_count = 0;
    repeat (80) @(posedge hclk);
    chk({31'h0, tick_count >= 9 && tick_count <= 11}, 32'h1);
    wr(GC1_ADDR, 32'h00000004);
    tick_count = 0;
    repeat (320) @(posedge hclk);
    chk({31'h0, tick_count >= 9 && tick_count <= 11}, 32'h1);
    wr(GC1_ADDR, 32'h00000000);
    // A tick launched at the write edge is not a disabled-age tick
    settle;
    tick_count = 0;
    repeat (200) @(posedge hclk);
    chk(tick_count, 32'h0);
    wr(GC1_ADDR, 32'h00000004);
    $display("test aging done");
  endtask

  task automatic t_link_age;
    all_count = 0;
    @(posedge hclk);
    link_up <= 5'h1B;
    repeat (24) @(posedge hclk);
    chk(all_count, 32'h0);
    link_up <= 5'h1F;
    wr(GC0_ADDR, 32'h00000001);
    repeat (6) @(posedge hclk);
    all_count = 0;
    link_up <= 5'h1D;
    repeat (24) @(posedge hclk);
    chk(all_count, 32'h1);
    link_up <= 5'h1F;
    $display("test link age done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    conclude;
  end

  // Main sequence
  initial begin
    fail_count = 0;
    cmp_count = 0;
    tick_count = 0;
    all_count = 0;
    rm_mask = 32'h0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pause_strap = 1'b1;
    link_up = 5'h1F;
    hdr_valid = 1'b0;
    hdr_len_type = 16'h0;
    hdr_da = 48'h0;
    hdr_is_flow_ctrl = 1'b0;
    hdr_payload_len = 16'h0;
    an_tx_pause = 5'h15;
    an_rx_pause = 5'h0A;
    learn_disable = 5'h01;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_regs;
    t_pause;
    t_header;
    t_flush;
    t_aging;
    t_link_age;
    conclude;
  end
endmodule // switch_global_control_bits_bench
